// [hw/chop_map.svh]
// Constants of the chopping current regulator: timing, scaling, register map.
// Assumes a 100 MHz mclk; included by every design file except the package.
`ifndef CHOP_MAP_SVH
`define CHOP_MAP_SVH

// Clock period and the fixed off times for each selection level.
`define CLK_NS         10
`define TOFF_LO_NS     20000
`define TOFF_Z_NS      10000
`define TOFF_HI_NS     30000
`define TOFF_LO_CYC    (`TOFF_LO_NS / `CLK_NS)
`define TOFF_Z_CYC     (`TOFF_Z_NS / `CLK_NS)
`define TOFF_HI_CYC    (`TOFF_HI_NS / `CLK_NS)

// Blanking interval, also the least drive time of a cycle.
`define BLANK_NS       1800
`define BLANK_CYC      ((`BLANK_NS + `CLK_NS - 1) / `CLK_NS)

// Attenuation of the reference times ten, full torque in eighths, full sine weight.
`define ATTEN_X10      66
`define TORQUE_FULL    8
`define SINE_FULL_MV   500
`define ZERO_MV        10'h002

// Register offsets.
`define REG_POS        8'h00
`define REG_VREF       8'h04
`define REG_STAT       8'h08
`define REG_TRIP       8'h0c

// Register reset values and field positions.
`define POS_RST        7'h01
`define VREF_RST       12'hce4
`define TRIP_B_LSB     16
`define STAT_INC_LSB   8
`define STAT_TQ_LSB    10
`define STAT_TOFF_LSB  14

`endif

// [hw/chop_pkg.sv]
// Types shared by the chopping current regulator and its bridges.
// Assumes nothing of its surroundings.
package chop_pkg;

    // Level seen on a three-state setting pin.
    typedef enum logic [1:0] {TRI_0, TRI_Z, TRI_1} tri_t;

    // Decay applied during an off interval.
    typedef enum logic [2:0] {DM_SLOW, DM_FAST, DM_MIX_BLANK, DM_MIX_8, DM_MIX_4, DM_MIX_2} decay_t;

    // Phases of one bridge within a cycle.
    typedef enum logic [2:0] {ST_BLANK, ST_DRIVE, ST_FAST, ST_COAST, ST_SLOW} bridge_st_t;

endpackage

// [hw/chop_trip_ref.sv]
// Trip threshold of one winding from reference, torque and sine code.
// Assumes steady inputs on mclk; the output is combinational.
`timescale 1ns/1ns
`include "chop_map.svh"
module chop_trip_ref
    import chop_pkg::*;
(
    // Settings.
    input  wire logic [11:0] vref_mv,
    input  wire logic [3:0]  torque8,
    input  wire logic [4:0]  sine_code,
    // Threshold on the sense voltage in millivolts.
    output logic      [9:0]  trip_mv
);
    // sine weight table
    // Sine weight per code, as sense millivolts at full scale.
    localparam logic [8:0] SINE_MV [0:31] = '{
        9'h000, 9'h019, 9'h032, 9'h04b, 9'h064, 9'h078, 9'h091, 9'h0aa,
        9'h0be, 9'h0d7, 9'h0eb, 9'h0ff, 9'h118, 9'h12c, 9'h13b, 9'h14f,
        9'h163, 9'h172, 9'h181, 9'h190, 9'h19f, 9'h1ae, 9'h1b8, 9'h1c2,
        9'h1cc, 9'h1d6, 9'h1e0, 9'h1e5, 9'h1ea, 9'h1ef, 9'h1f4, 9'h1f4};
    localparam logic [28:0] DIVISOR = 29'(`ATTEN_X10 * `TORQUE_FULL * `SINE_FULL_MV);

    logic [28:0] prod;

    assign prod = 29'(vref_mv) * 29'(torque8) * 29'(SINE_MV[sine_code]) * 29'h00a;
    assign trip_mv = 10'(prod / DIVISOR);

endmodule // chop_trip_ref

// [hw/chop_bridge.sv]
// Fixed off time chopper for one H-bridge: blank, drive, fast, coast, slow.
// Assumes registered comparator inputs and settings on the same clock.
`timescale 1ns/1ns
`include "chop_map.svh"
module chop_bridge
    import chop_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // Setup.
    input  wire logic        enable,
    input  wire logic        dir,
    input  wire logic [11:0] toff_cyc,
    input  wire logic [11:0] fast_cyc,
    // Comparator results.
    input  wire logic        trip,
    input  wire logic        near_zero,
    // Gates: high 1, low 1, high 2, low 2.
    output logic      [3:0]  fets_q
);
    bridge_st_t  st_q, st_d;
    logic [11:0] cnt_q, cnt_d;
    logic [3:0]  fets_d;

    // Counter end points and gate patterns.
    wire       blank_end  = cnt_q == 12'(`BLANK_CYC - 1);
    // At or past the end point, so a setting shortened mid-interval cannot make the counter wrap.
    wire       off_end    = cnt_q >= toff_cyc - 12'h001;
    wire       fast_end   = cnt_q >= fast_cyc - 12'h001;
    wire       in_off     = st_q == ST_FAST || st_q == ST_COAST || st_q == ST_SLOW;
    wire [3:0] drive_fets = dir ? 4'h6 : 4'h9;
    wire [3:0] rev_fets   = dir ? 4'h9 : 4'h6;

    // Next phase; trip is only looked at in the drive phase, near_zero only in fast decay.
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q + 12'h001;
        if (!enable) begin
            st_d  = ST_BLANK;
            cnt_d = 12'h000;
        end else begin
            case (st_q)
                ST_BLANK: begin
                    if (blank_end) begin
                        st_d  = ST_DRIVE;
                        cnt_d = 12'h000;
                    end
                end
                ST_DRIVE: begin
                    cnt_d = 12'h000;
                    if (trip) begin
                        st_d = (fast_cyc != 12'h000) ? ST_FAST : ST_SLOW;
                    end
                end
                ST_FAST, ST_COAST, ST_SLOW: begin
                    if (off_end) begin
                        st_d  = ST_BLANK;
                        cnt_d = 12'h000;
                    end else if (st_q != ST_SLOW && fast_end) begin
                        st_d = ST_SLOW;
                    end else if (st_q == ST_FAST && near_zero) begin
                        st_d = ST_COAST;
                    end
                end
                default: begin
                    st_d  = ST_BLANK;
                    cnt_d = 12'h000;
                end
            endcase
        end
    end

    assign fets_d = !enable ? 4'h0 :
                    (st_d == ST_BLANK || st_d == ST_DRIVE) ? drive_fets :
                    (st_d == ST_FAST) ? rev_fets :
                    (st_d == ST_SLOW) ? 4'h5 : 4'h0;

    // Phase, counter and gate registers.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q   <= ST_BLANK;
            cnt_q  <= 12'h000;
            fets_q <= 4'h0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            fets_q <= fets_d;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_TRIP_STARTS_OFF: assert property (
        enable && st_q == ST_DRIVE && trip |=> in_off && cnt_q == 12'h000 && fets_q != drive_fets)
        else $error("Trip did not start the off interval.");
    AST_OFF_ENDS: assert property (enable && in_off && off_end |=> st_q == ST_BLANK && fets_q == drive_fets)
        else $error("Off interval end did not restart drive.");
    AST_FAST_REVERSE: assert property (st_q == ST_FAST |-> fets_q == rev_fets)
        else $error("Fast decay does not reverse the bridge.");
    AST_NEAR_ZERO_OFF: assert property (
        enable && st_q == ST_FAST && near_zero && !off_end && !fast_end |=> fets_q == 4'h0)
        else $error("Bridge not disabled near zero current.");
    AST_SLOW_LOWSIDE: assert property (st_q == ST_SLOW |-> fets_q == 4'h5)
        else $error("Slow decay gates are wrong.");
    AST_MIX_SWITCH: assert property (enable && st_q == ST_FAST && fast_end && !off_end |=> st_q == ST_SLOW)
        else $error("Mixed decay did not switch to slow.");
    AST_BLANK_MIN: assert property (
        $rose(st_q == ST_DRIVE) |-> $past(st_q) == ST_BLANK && $past(cnt_q) == 12'(`BLANK_CYC - 1))
        else $error("Drive phase began before the blanking interval ended.");
    AST_OFF_HOLDS: assert property (enable && in_off && !off_end |=> in_off)
        else $error("Off interval left early.");
    COV_FAST_TO_SLOW: cover property (st_q == ST_FAST ##1 st_q == ST_SLOW);
    COV_COAST: cover property (st_q == ST_COAST);

endmodule // chop_bridge

// [hw/chopping_current_regulator.sv]
// Chopping current regulator for two H-bridges with an AXI4-Lite register port.
// Assumes sense samples in millivolts from an ADC on mclk and asynchronous
// three-state setting pins, each seen as a driven-high and a floating level.
//
// Summary of operation
// - Trip at threshold enters decay for fixed time.
// - Off time end re-enables drive, new cycle.
// - Off time pin: low 20, float 10, high 30 us.
// - Reference scaled by torque, then by sine weight.
// - Scaled reference divided by 6.6 before compare.
// - Torque pins scale linearly; 11 disables outputs.
// - Codes 31, 30 give 500 mV; 0 gives zero.
// - Microstep position maps to signed winding currents.
// - Fast decay reverses bridge, disables near zero.
// - Slow decay turns both low sides on.
// - Mixed decay starts fast then goes slow.
// - Decay pins decode low, high and floating.
// - Decay chosen separately for rising, falling current.
// - 1Z gives slow/12.5% mixed; 11 slow/fast.
// - Sense ignored during blanking, the least drive time.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "chop_map.svh"
module chopping_current_regulator
    import chop_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // AXI4-Lite write address and data.
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // AXI4-Lite write response.
    output logic      [1:0]  bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read.
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Three-state setting pins.
    input  wire logic        offtime_select_high,
    input  wire logic        offtime_select_float,
    input  wire logic        torque_sel_bit1_high,
    input  wire logic        torque_sel_bit1_float,
    input  wire logic        torque_sel_bit0_high,
    input  wire logic        torque_sel_bit0_float,
    input  wire logic        decay_sel_bit1_high,
    input  wire logic        decay_sel_bit1_float,
    input  wire logic        decay_sel_bit0_high,
    input  wire logic        decay_sel_bit0_float,
    // Winding sense samples.
    input  wire logic [9:0]  winding_sense_input_a_mv,
    input  wire logic [9:0]  winding_sense_input_b_mv,
    // Bridge gates: high 1, low 1, high 2, low 2.
    output logic      [3:0]  bridge_a_fets,
    output logic      [3:0]  bridge_b_fets
);
    // Pin order: off time, torque high, torque low, decay high, decay low.
    localparam int NPIN = 5;

    logic [9:0]  pin_meta_q, pin_sync_q;
    tri_t        tri_v [NPIN];
    logic [6:0]  pos_q;
    logic [11:0] vref_q;
    logic        aw_full_q, w_full_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]  bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [9:0]  trip_mv [2];
    logic [3:0]  fets_w [2];
    logic [1:0]  inc_w;
    logic [9:0]  sense_w [2];

    // Pins pass two flip-flops before any decode.
    wire [9:0] pin_raw = {decay_sel_bit0_float, decay_sel_bit0_high, decay_sel_bit1_float, decay_sel_bit1_high,
                          torque_sel_bit0_float, torque_sel_bit0_high, torque_sel_bit1_float, torque_sel_bit1_high,
                          offtime_select_float, offtime_select_high};

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_q <= 10'h000;
            pin_sync_q <= 10'h000;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
        end
    end

    // Each pin decodes to low, floating or high; floating wins.
    for (genvar g = 0; g < NPIN; g++) begin : g_pin
        assign tri_v[g] = pin_sync_q[2*g+1] ? TRI_Z : (pin_sync_q[2*g] ? TRI_1 : TRI_0);

        AST_TRI_DECODE: assert property (@(posedge mclk) disable iff (!rst_b)
            pin_raw[2*g+1] |-> ##2 tri_v[g] == TRI_Z)
            else $error("Floating pin not decoded as third level.");
    end

    // torque in eighths, 11 gives zero
    wire [3:0] tq_idx  = 4'(tri_v[1]) * 4'h3 + 4'(tri_v[2]);
    wire [3:0] torque8 = 4'h8 - tq_idx;
    wire       drive_en = torque8 != 4'h0;
    wire [3:0] dec_idx = 4'(tri_v[3]) * 4'h3 + 4'(tri_v[4]);

    wire [11:0] toff_cyc = (tri_v[0] == TRI_Z) ? 12'(`TOFF_Z_CYC) :
                           (tri_v[0] == TRI_1) ? 12'(`TOFF_HI_CYC) : 12'(`TOFF_LO_CYC);

    // Decay for one direction of current change.
    function automatic decay_t decay_of(input logic [3:0] idx, input logic rising);
        decay_t m;
        m = DM_SLOW;
        case (idx)
            4'h0: m = DM_SLOW;
            4'h1: m = rising ? DM_SLOW : DM_MIX_4;
            4'h2: m = rising ? DM_SLOW : DM_MIX_BLANK;
            4'h3: m = DM_MIX_BLANK;
            4'h4: m = DM_MIX_2;
            4'h5: m = DM_MIX_4;
            4'h6: m = rising ? DM_SLOW : DM_MIX_2;
            4'h7: m = rising ? DM_SLOW : DM_MIX_8;
            4'h8: m = rising ? DM_SLOW : DM_FAST;
            default: m = DM_SLOW;
        endcase
        return m;
    endfunction

    // Fast part of the off interval in cycles.
    function automatic logic [11:0] fast_of(input decay_t m, input logic [11:0] toff);
        logic [11:0] f;
        f = 12'h000;
        case (m)
            DM_FAST:      f = toff;
            DM_MIX_BLANK: f = 12'(`BLANK_CYC);
            DM_MIX_8:     f = toff >> 3;
            DM_MIX_4:     f = toff >> 2;
            DM_MIX_2:     f = toff >> 1;
            default:      f = 12'h000;
        endcase
        return f;
    endfunction

    assign sense_w[0] = winding_sense_input_a_mv;
    assign sense_w[1] = winding_sense_input_b_mv;

    // Per winding: sine code, trip reference, comparator, decay, bridge.
    for (genvar w = 0; w < 2; w++) begin : g_wind
        logic [4:0] prev_code_q;
        logic       prev_sign_q, inc_q, trip_q, zero_q;

        wire [6:0] k    = pos_q - 7'h01 + ((w == 0) ? 7'h20 : 7'h00);
        wire [5:0] idx  = k[5] ? 6'(7'h40 - {1'b0, k[5:0]}) : k[5:0];
        wire [4:0] code = idx[5] ? 5'h1f : idx[4:0];
        wire       sign = k[6];
        decay_t    mode;
        assign mode = decay_of(dec_idx, inc_q);
        wire [11:0] fast_cyc = fast_of(mode, toff_cyc);

        chop_trip_ref u_ref (
            .vref_mv   (vref_q),
            .torque8   (torque8),
            .sine_code (code),
            .trip_mv   (trip_mv[w])
        );

        // Comparator and the rising or falling current flag.
        always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                trip_q      <= 1'b0;
                zero_q      <= 1'b0;
                prev_code_q <= 5'h00;
                prev_sign_q <= 1'b0;
                inc_q       <= 1'b1;
            end else begin
                trip_q <= sense_w[w] >= trip_mv[w];
                zero_q <= sense_w[w] <= `ZERO_MV;
                if (code != prev_code_q || sign != prev_sign_q) begin
                    inc_q       <= (sign != prev_sign_q) || (code > prev_code_q);
                    prev_code_q <= code;
                    prev_sign_q <= sign;
                end
            end
        end
        assign inc_w[w] = inc_q;

        chop_bridge u_bridge (
            .mclk      (mclk),
            .rst_b     (rst_b),
            .enable    (drive_en),
            .dir       (sign),
            .toff_cyc  (toff_cyc),
            .fast_cyc  (fast_cyc),
            .trip      (trip_q),
            .near_zero (zero_q),
            .fets_q    (fets_w[w])
        );

        AST_FULL_TRIP: assert property (@(posedge mclk) disable iff (!rst_b)
            torque8 == 4'h8 && vref_q == 12'hce4 && code >= 5'h1e |-> trip_mv[w] == 10'h1f4)
            else $error("Full scale trip level is not 500 mV.");
        AST_HALF_TRIP: assert property (@(posedge mclk) disable iff (!rst_b)
            torque8 == 4'h4 && vref_q == 12'hce4 && code == 5'h13 |-> trip_mv[w] == 10'h0c8)
            else $error("Half torque trip level at code 19 is not 200 mV.");
        AST_POS_END: assert property (@(posedge mclk) disable iff (!rst_b)
            pos_q == 7'h00 |-> code == ((w == 0) ? 5'h1f : 5'h01) && sign == (w == 1))
            else $error("Last microstep position maps wrongly.");
        AST_RISE_SLOW: assert property (@(posedge mclk) disable iff (!rst_b)
            inc_q && dec_idx inside {4'h0, 4'h1, 4'h2, 4'h6, 4'h7, 4'h8} |-> fast_cyc == 12'h000)
            else $error("Rising current not in slow decay.");
        AST_FALL_MODES: assert property (@(posedge mclk) disable iff (!rst_b)
            !inc_q && (dec_idx == 4'h7 || dec_idx == 4'h8) |-> fast_cyc == ((dec_idx == 4'h8) ? toff_cyc : toff_cyc >> 3))
            else $error("Falling current decay for 1Z or 11 is wrong.");
    end

    AST_TORQUE_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
        torque8 == 4'h0 |=> bridge_a_fets == 4'h0 && bridge_b_fets == 4'h0)
        else $error("Zero torque did not disable the outputs.");
    AST_OFFTIME_SELECT: assert property (@(posedge mclk) disable iff (!rst_b)
        tri_v[0] == TRI_Z |-> toff_cyc == 12'h3e8)
        else $error("Floating off time pin is not 10 us.");
    COV_WRITE: cover property (@(posedge mclk) disable iff (!rst_b) bvalid_q && bready);

    assign bridge_a_fets = fets_w[0];
    assign bridge_b_fets = fets_w[1];

    // Write channel: address and data taken in either order, committed together.
    wire aw_take  = awvalid && awready_q;
    wire w_take   = wvalid && wready_q;
    wire commit   = aw_full_q && w_full_q && !bvalid_q;
    wire aw_full_d = (aw_full_q || aw_take) && !commit;
    wire w_full_d  = (w_full_q || w_take) && !commit;
    wire bvalid_d  = commit || (bvalid_q && !bready);
    wire wr_known  = aw_addr_q == `REG_POS || aw_addr_q == `REG_VREF ||
                     aw_addr_q == `REG_STAT || aw_addr_q == `REG_TRIP;
    wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wire [31:0] pos_new  = ({25'h0, pos_q} & ~wmask) | (w_data_q & wmask);
    wire [31:0] vref_new = ({20'h0, vref_q} & ~wmask) | (w_data_q & wmask);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awready_q <= !aw_full_d;
            wready_q  <= !w_full_d;
            bvalid_q  <= bvalid_d;
            if (aw_take) aw_addr_q <= awaddr;
            if (w_take) w_data_q <= wdata;
            if (w_take) w_strb_q <= wstrb;
            if (commit) bresp_q <= wr_known ? 2'h0 : 2'h2;
        end
    end

    // Writable registers: microstep position and reference millivolts.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pos_q  <= `POS_RST;
            vref_q <= `VREF_RST;
        end else if (commit) begin
            if (aw_addr_q == `REG_POS) pos_q <= pos_new[6:0];
            if (aw_addr_q == `REG_VREF) vref_q <= vref_new[11:0];
        end
    end

    // Read channel: one cycle from address to data.
    wire ar_take  = arvalid && arready_q;
    wire rvalid_d = ar_take || (rvalid_q && !rready);
    wire [31:0] stat_word = {16'h0, 2'(tri_v[0]), torque8, inc_w, fets_w[1], fets_w[0]};
    wire [31:0] trip_word = {6'h00, trip_mv[1], 6'h00, trip_mv[0]};
    wire rd_known = araddr == `REG_POS || araddr == `REG_VREF ||
                    araddr == `REG_STAT || araddr == `REG_TRIP;
    wire [31:0] rd_mux = (araddr == `REG_POS) ? {25'h0, pos_q} :
                         (araddr == `REG_VREF) ? {20'h0, vref_q} :
                         (araddr == `REG_STAT) ? stat_word :
                         (araddr == `REG_TRIP) ? trip_word : 32'h0000_0000;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= 2'h0;
        end else begin
            arready_q <= !rvalid_d;
            rvalid_q  <= rvalid_d;
            if (ar_take) rdata_q <= rd_mux;
            if (ar_take) rresp_q <= rd_known ? 2'h0 : 2'h2;
        end
    end

    COV_READ: cover property (@(posedge mclk) disable iff (!rst_b) rvalid_q && rready);

    // Bus outputs straight from their flip-flops.
    assign awready = awready_q;
    assign wready  = wready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

endmodule // chopping_current_regulator

// [test/winding_model.sv]
// Winding with sense resistor: current builds while driven, decays on reversed or both low-side gates, holds otherwise.
// Assumes gates {high1, low1, high2, low2} of one bridge on mclk; sense in mV.
`timescale 1ns/1ns
module winding_model (
    // Clock and gates.
    input  wire logic       mclk,
    input  wire logic [3:0] fets,
    // Sense voltage.
    output logic      [9:0] sense_mv
);
    logic [3:0] tick_q = 4'h0;
    initial sense_mv = 10'h000;
    // Drive adds 1 mV a cycle, reversed gates take 4, both low sides 1 per 16.
    always @(posedge mclk) begin
        tick_q <= tick_q + 4'h1;
        if (fets == 4'h9 && sense_mv != 10'h3ff) sense_mv <= sense_mv + 10'h001;
        else if (fets == 4'h6) sense_mv <= (sense_mv > 10'h004) ? sense_mv - 10'h004 : 10'h000;
        else if (fets == 4'h5 && tick_q == 4'h0 && sense_mv != 10'h000) sense_mv <= sense_mv - 10'h001;
    end
endmodule // winding_model

// [test/chopping_current_regulator_tb_top.sv]
// Bench: registers, trip levels, off times and decay of the chopper.
// Assumes a winding model on each bridge and a 100 MHz mclk.
`timescale 1ns/1ns
module chopping_current_regulator_tb_top;
    logic        mclk, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  fa, fb;
    logic [1:0]  bresp, rresp;
    logic [9:0]  pin, sa, sb;
    int          error_cnt = 0, n_compared = 0, cyc = 0;
    chopping_current_regulator dut (.mclk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .offtime_select_high(pin[9]), .offtime_select_float(pin[8]), .torque_sel_bit1_high(pin[7]),
        .torque_sel_bit1_float(pin[6]), .torque_sel_bit0_high(pin[5]), .torque_sel_bit0_float(pin[4]),
        .decay_sel_bit1_high(pin[3]), .decay_sel_bit1_float(pin[2]), .decay_sel_bit0_high(pin[1]),
        .decay_sel_bit0_float(pin[0]), .winding_sense_input_a_mv(sa), .winding_sense_input_b_mv(sb),
        .bridge_a_fets(fa), .bridge_b_fets(fb));
    winding_model wa (.mclk, .fets(fa), .sense_mv(sa));
    winding_model wb (.mclk, .fets(fb), .sense_mv(sb));
    // Clock, and a cycle ceiling that cuts a hang short.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Bus write and read; each channel holds until its own ready.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge mclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, e});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge mclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
    endtask
    // Sets the pins, then measures one whole off interval of bridge A.
    task automatic off_run(input logic [9:0] p, output int n, output int ns, output int nf);
        pin <= p;
        repeat (3) @(posedge mclk);
        while (fa !== 4'h9) @(posedge mclk);
        while (fa === 4'h9) @(posedge mclk);
        {n, ns, nf} = 0;
        while (fa !== 4'h9) begin
            n++;
            ns += int'(fa === 4'h5);
            nf += int'(fa === 4'h6);
            @(posedge mclk);
        end
    endtask
    task automatic regs_test();
        rd(8'h04, 32'hce4, 2'h0);
        rd(8'h10, 32'h0, 2'h2);
        wr(8'h10, 32'h5, 2'h2);
        wr(8'h0c, 32'h1234, 2'h0);
        rd(8'h0c, 32'h1f4, 2'h0);
        wr(8'h00, 32'h0, 2'h0);
        rd(8'h0c, 32'h1901f4, 2'h0);
        wr(8'h00, 32'h1, 2'h0);
        rd(8'h00, 32'h1, 2'h0);
    endtask
    task automatic torque_test();
        pin <= 10'h050;
        repeat (3) @(posedge mclk);
        rd(8'h0c, 32'hfa, 2'h0);
        wr(8'h00, 32'h14, 2'h0);
        rd(8'h0c, 32'hc80096, 2'h0);
        wr(8'h00, 32'h1, 2'h0);
        wr(8'h04, 32'h672, 2'h0);
        rd(8'h0c, 32'h7d, 2'h0);
        pin <= 10'h0a0;
        repeat (4) @(posedge mclk);
        chk({24'h0, fa, fb}, 32'h0);
        rd(8'h08, 32'h100, 2'h0);
    endtask
    // Mixed and fast decays per selection; position 3 makes winding A current fall.
    task automatic decay_test();
        int n, ns, nf;
        logic [9:0] sel_c[4] = '{10'h104, 10'h106, 10'h109, 10'h10a};
        int slow_c[4] = '{820, 750, 875, 0};
        for (int i = 0; i < 4; i++) begin
            if (i == 2) wr(8'h00, 32'h3, 2'h0);
            off_run(sel_c[i], n, ns, nf);
            chk(n, 1000);
            chk(ns, slow_c[i]);
            chk(nf != 0, 1);
        end
    endtask
    task automatic off_test();
        int n, ns, nf;
        int exp_c[3] = '{2000, 1000, 3000};
        for (int i = 0; i < 3; i++) begin
            off_run({2'(i), 8'h00}, n, ns, nf);
            chk(n, exp_c[i]);
            chk(ns, exp_c[i]);
        end
        off_run(10'h105, n, ns, nf);
        chk(n, 1000);
        chk(ns, 500);
        chk(nf != 0, 1);
    endtask
    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Reset for eight cycles, then the scenarios in turn.
    initial begin
        {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, pin} = 58'h0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        regs_test();
        torque_test();
        off_test();
        decay_test();
        complete_run();
    end
endmodule // chopping_current_regulator_tb_top
